/* src/dlbae_pkg.sv */
// Constants and types for the logic, jump and all-pass execution unit
package dlbae_pkg;
  // ==========================================================
  // Opcodes (top byte of the instruction word)
  localparam logic [7:0] OP_BITWISE_INVERT = 8'hA0;
  localparam logic [7:0] OP_REG_OR = 8'hA2;
  localparam logic [7:0] OP_OR_IMMEDIATE = 8'hA4;
  localparam logic [7:0] OP_REG_AND = 8'hA6;
  localparam logic [7:0] OP_AND_IMMEDIATE = 8'hA8;
  localparam logic [7:0] OP_REG_XOR = 8'hAA;
  localparam logic [7:0] OP_XOR_IMMEDIATE = 8'hAC;
  localparam logic [7:0] OP_JUMP_IF_NONNEGATIVE = 8'hAE;
  localparam logic [7:0] OP_JUMP_IF_NEGATIVE = 8'hB0;
  localparam logic [7:0] OP_JUMP_IF_NONZERO = 8'hB2;
  localparam logic [7:0] OP_JUMP_IF_ZERO = 8'hB4;
  localparam logic [7:0] OP_JUMP_IF_SIGN_DIFFERS = 8'hB6;
  localparam logic [7:0] OP_JUMP_ALWAYS = 8'hB8;
  localparam logic [7:0] OP_ALLPASS_FIXED_FIRST = 8'hC0;
  localparam logic [7:0] OP_ALLPASS_FIXED_SECOND = 8'hC2;
  localparam logic [7:0] OP_ALLPASS_REGCOEF_FIRST = 8'hC4;
  localparam logic [7:0] OP_ALLPASS_REGCOEF_SECOND = 8'hC6;
  localparam logic [7:0] OP_ALLPASS_ALLREG_FIRST = 8'hC8;
  localparam logic [7:0] OP_ALLPASS_ALLREG_SECOND = 8'hCA;
  // ==========================================================
  // Instruction field positions
  localparam int OPC_MSB = 31;
  localparam int OPC_LSB = 24;
  localparam int RX_MSB = 20;
  localparam int RX_LSB = 16;
  localparam int RY_MSB = 4;
  localparam int RY_LSB = 0;
  localparam int IMM_MSB = 15;
  localparam int IMM_LSB = 0;
  localparam int COEF_MSB = 23;
  localparam int COEF_LSB = 16;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 0;
  localparam int OFS_MSB = 15;
  localparam int OFS_LSB = 0;
  // ==========================================================
  // Register selector codes and reset values
  localparam logic [4:0] SEL_SHORT_ACC = 5'h10;
  localparam logic [4:0] SEL_FLAGS = 5'h11;
  localparam logic [3:0] PARAM_REG_IDX = 4'hF;
  localparam logic [31:0] SHORT_ACC_RST = 32'h00000000;
  localparam logic [31:0] GPR_RST = 32'h00000000;
  localparam logic [14:0] DMEM_ADDR_RST = 15'h0000;
  localparam logic [15:0] DMEM_DATA_RST = 16'h0000;
  // ==========================================================
  // Execution state
  typedef enum logic [0:0] {ST_IDLE, ST_RD_WAIT} dlbae_state_e;
endpackage

/* src/dlbae_exec.sv */
// Execution unit for bitwise logic, forward jumps and paired all-pass steps
`timescale 1ns/100ps

module dlbae_exec
  import dlbae_pkg::*;
#(
  parameter int PC_W = 10
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Instruction from the sequencer
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [PC_W-1:0] instr_pc,
  output logic instr_ready,
  output logic exec_done,
  // Program change clears the accumulator
  input wire logic program_change,
  // Register load port from the rest of the core
  input wire logic reg_wr_en,
  input wire logic [3:0] reg_wr_idx,
  input wire logic [31:0] reg_wr_data,
  input wire logic [31:0] flags_in,
  // Jump result to the sequencer
  output logic jump_taken,
  output logic [PC_W-1:0] jump_target,
  // Delay memory
  output logic dmem_rd_req,
  output logic [14:0] dmem_addr,
  input wire logic dmem_rd_valid,
  input wire logic [15:0] dmem_rd_data,
  output logic dmem_wr_en,
  output logic [15:0] dmem_wr_data,
  // Visible core state
  output logic [31:0] short_accumulator,
  output logic [31:0] parameter_register
);

  // ==========================================================
  // State
  typedef struct packed {
    dlbae_state_e state;
    logic [15:0][31:0] gpr;
    logic [31:0] acc;
    logic [31:0] coef;
    logic [14:0] addr;
    logic rd_req;
    logic wr_en;
    logic [15:0] wr_data;
    logic taken;
    logic [PC_W-1:0] target;
    logic done;
  } dlbae_core_s;

  dlbae_core_s s_r;
  dlbae_core_s s_nxt;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] dlbae_rd_reg(input logic [4:0] sel, input logic [15:0][31:0] g,
                                               input logic [31:0] a, input logic [31:0] f);
    logic [31:0] v;
    v = 32'h00000000;
    if (sel[4] == 1'b0)
    begin
      v = g[sel[3:0]];
    end
    else if (sel == SEL_SHORT_ACC)
    begin
      v = a;
    end
    else if (sel == SEL_FLAGS)
    begin
      v = f;
    end
    return v;
  endfunction

  // S.31 times S.31, result kept in S.31
  function automatic logic [31:0] dlbae_fmul(input logic [31:0] a, input logic [31:0] b);
    logic signed [63:0] p;
    p = $signed(a) * $signed(b);
    return p[62:31];
  endfunction

  logic [7:0] opc;
  logic [31:0] opa;
  logic [31:0] opb;
  logic [31:0] imm_ext;
  logic [31:0] coef_fixed;
  logic [14:0] addr_imm;
  logic [PC_W-1:0] ofs;
  logic fire;

  assign opc = instr_word[OPC_MSB:OPC_LSB];
  assign opa = dlbae_rd_reg(instr_word[RX_MSB:RX_LSB], s_r.gpr, s_r.acc, flags_in);
  assign opb = dlbae_rd_reg(instr_word[RY_MSB:RY_LSB], s_r.gpr, s_r.acc, flags_in);
  assign imm_ext = {16'h0000, instr_word[IMM_MSB:IMM_LSB]};
  assign coef_fixed = {instr_word[COEF_MSB:COEF_LSB], 24'h000000};
  assign addr_imm = instr_word[ADDR_MSB:ADDR_LSB];
  // Unsigned offset cut to the low PC_W bits of the field: forward only
  assign ofs = PC_W'(instr_word[OFS_MSB:OFS_LSB]);
  assign fire = instr_valid && (s_r.state == ST_IDLE);

  // ==========================================================
  // Next state
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.taken = 1'b0;
    s_nxt.wr_en = 1'b0;
    s_nxt.done = 1'b0;
    // Only general registers are loadable; flags stay read-only
    if (reg_wr_en)
    begin
      s_nxt.gpr[reg_wr_idx] = reg_wr_data;
    end
    if (s_r.state == ST_RD_WAIT)
    begin
      if (dmem_rd_valid)
      begin
        // Tail is zero-appended to S.31 before the multiply
        s_nxt.acc = dlbae_fmul({dmem_rd_data, 16'h0000}, s_r.coef) + s_r.acc;
        s_nxt.gpr[PARAM_REG_IDX] = {dmem_rd_data, 16'h0000};
        s_nxt.rd_req = 1'b0;
        s_nxt.state = ST_IDLE;
        s_nxt.done = 1'b1;
      end
    end
    else if (instr_valid)
    begin
      s_nxt.done = 1'b1;
      s_nxt.target = instr_pc + ofs;
      unique case (opc)
        OP_BITWISE_INVERT: s_nxt.acc = ~opa;
        OP_REG_OR: s_nxt.acc = opa | opb;
        OP_REG_AND: s_nxt.acc = opa & opb;
        OP_REG_XOR: s_nxt.acc = opa ^ opb;
        OP_OR_IMMEDIATE: s_nxt.acc = opa | imm_ext;
        OP_AND_IMMEDIATE: s_nxt.acc = opa & imm_ext;
        OP_XOR_IMMEDIATE: s_nxt.acc = opa ^ imm_ext;
        OP_JUMP_IF_NONNEGATIVE: s_nxt.taken = ~opa[31];
        OP_JUMP_IF_NEGATIVE: s_nxt.taken = opa[31];
        OP_JUMP_IF_NONZERO: s_nxt.taken = (opa != 32'h00000000);
        OP_JUMP_IF_ZERO: s_nxt.taken = (opa == 32'h00000000);
        OP_JUMP_IF_SIGN_DIFFERS: s_nxt.taken = opa[31] ^ s_r.acc[31];
        OP_JUMP_ALWAYS: s_nxt.taken = 1'b1;
        OP_ALLPASS_FIXED_FIRST,
        OP_ALLPASS_REGCOEF_FIRST,
        OP_ALLPASS_ALLREG_FIRST:
        begin
          // Result lands only once the tail read returns
          s_nxt.done = 1'b0;
          s_nxt.state = ST_RD_WAIT;
          s_nxt.rd_req = 1'b1;
          s_nxt.addr = addr_imm;
          s_nxt.coef = coef_fixed;
          if (opc == OP_ALLPASS_REGCOEF_FIRST)
          begin
            s_nxt.coef = -opa;
          end
          if (opc == OP_ALLPASS_ALLREG_FIRST)
          begin
            s_nxt.coef = -opa;
            s_nxt.addr = opb[14:0];
          end
        end
        OP_ALLPASS_FIXED_SECOND:
        begin
          s_nxt.wr_en = 1'b1;
          s_nxt.addr = addr_imm;
          s_nxt.wr_data = s_r.acc[31:16];
          s_nxt.acc = dlbae_fmul(s_r.acc, coef_fixed) + s_r.gpr[PARAM_REG_IDX];
        end
        OP_ALLPASS_REGCOEF_SECOND:
        begin
          s_nxt.wr_en = 1'b1;
          s_nxt.addr = addr_imm;
          s_nxt.wr_data = s_r.acc[31:16];
          s_nxt.acc = dlbae_fmul(s_r.acc, opa) + s_r.gpr[PARAM_REG_IDX];
        end
        OP_ALLPASS_ALLREG_SECOND:
        begin
          // Coefficient from upper field, address from lower field
          s_nxt.wr_en = 1'b1;
          s_nxt.addr = opb[14:0];
          s_nxt.wr_data = s_r.acc[31:16];
          s_nxt.acc = dlbae_fmul(s_r.acc, opa) + s_r.gpr[PARAM_REG_IDX];
        end
        default: s_nxt.done = 1'b1;
      endcase
    end
    // Program change overrides any accumulator update in the same cycle
    if (program_change)
    begin
      s_nxt.acc = SHORT_ACC_RST;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s_r.state <= ST_IDLE;
      s_r.gpr <= {16{GPR_RST}};
      s_r.acc <= SHORT_ACC_RST;
      s_r.coef <= GPR_RST;
      s_r.addr <= DMEM_ADDR_RST;
      s_r.rd_req <= 1'b0;
      s_r.wr_en <= 1'b0;
      s_r.wr_data <= DMEM_DATA_RST;
      s_r.taken <= 1'b0;
      s_r.target <= '0;
      s_r.done <= 1'b0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign instr_ready = (s_r.state == ST_IDLE);
  assign exec_done = s_r.done;
  assign jump_taken = s_r.taken;
  assign jump_target = s_r.target;
  assign dmem_rd_req = s_r.rd_req;
  assign dmem_addr = s_r.addr;
  assign dmem_wr_en = s_r.wr_en;
  assign dmem_wr_data = s_r.wr_data;
  assign short_accumulator = s_r.acc;
  assign parameter_register = s_r.gpr[PARAM_REG_IDX];

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_op(logic [7:0] code);
    fire && (opc == code) && !program_change;
  endsequence

  sequence s_tail_back;
    (s_r.state == ST_RD_WAIT) && dmem_rd_valid;
  endsequence

  a_invert_to_acc: assert property (s_op(OP_BITWISE_INVERT) |=>
    short_accumulator == ~$past(opa))
    else $error("invert result wrong");
  a_or_to_acc: assert property (s_op(OP_REG_OR) |=>
    short_accumulator == ($past(opa) | $past(opb)))
    else $error("or result wrong");
  a_and_to_acc: assert property (s_op(OP_REG_AND) |=>
    short_accumulator == ($past(opa) & $past(opb)))
    else $error("and result wrong");
  a_xor_to_acc: assert property (s_op(OP_REG_XOR) |=>
    short_accumulator == ($past(opa) ^ $past(opb)))
    else $error("xor result wrong");
  a_and_imm_zext: assert property (s_op(OP_AND_IMMEDIATE) |=>
    short_accumulator[31:16] == 16'h0000)
    else $error("immediate not zero extended");
  a_jump_nonneg: assert property (s_op(OP_JUMP_IF_NONNEGATIVE) |=>
    jump_taken == !$past(opa[31]))
    else $error("nonnegative jump wrong");
  a_jump_neg: assert property (s_op(OP_JUMP_IF_NEGATIVE) |=>
    jump_taken == $past(opa[31]))
    else $error("negative jump wrong");
  a_jump_nonzero: assert property (s_op(OP_JUMP_IF_NONZERO) |=>
    jump_taken == ($past(opa) != 32'h00000000))
    else $error("nonzero jump wrong");
  a_jump_zero: assert property (s_op(OP_JUMP_IF_ZERO) |=>
    jump_taken == ($past(opa) == 32'h00000000))
    else $error("zero jump wrong");
  a_jump_sign: assert property (s_op(OP_JUMP_IF_SIGN_DIFFERS) |=>
    jump_taken == ($past(opa[31]) ^ $past(s_r.acc[31])))
    else $error("sign jump wrong");
  // Pulse ends unless another instruction was taken right behind it
  a_jump_always: assert property (s_op(OP_JUMP_ALWAYS) |=>
    jump_taken ##1 (!jump_taken || $past(fire)))
    else $error("unconditional jump missing");
  a_jump_forward: assert property (jump_taken |->
    jump_target == $past(instr_pc) + $past(ofs))
    else $error("jump target wrong");
  a_first_read: assert property (s_op(OP_ALLPASS_FIXED_FIRST) |=>
    dmem_rd_req && !instr_ready && dmem_addr == $past(addr_imm))
    else $error("first step read wrong");
  a_tail_saved: assert property (s_tail_back |=>
    parameter_register == {$past(dmem_rd_data), 16'h0000} && instr_ready && !dmem_rd_req)
    else $error("tail not saved");
  a_second_write: assert property (s_op(OP_ALLPASS_FIXED_SECOND) |=>
    dmem_wr_en && dmem_wr_data == $past(s_r.acc[31:16]))
    else $error("second step write wrong");
  a_allreg_addr: assert property (s_op(OP_ALLPASS_ALLREG_SECOND) |=>
    dmem_wr_en && dmem_addr == $past(opb[14:0]))
    else $error("all-register address wrong");
  a_prog_clear: assert property (program_change |=>
    short_accumulator == 32'h00000000)
    else $error("accumulator not cleared");

endmodule

/* test/dlbae_dmem_model.sv */
// Delay memory partner model with a read latency set by the bench
`timescale 1ns/100ps
module dlbae_dmem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Read wait in cycles; data returns lat+1 cycles after the request
  input wire logic [3:0] lat,
  // Memory port
  input wire logic dmem_rd_req,
  input wire logic [14:0] dmem_addr,
  input wire logic dmem_wr_en,
  input wire logic [15:0] dmem_wr_data,
  output logic dmem_rd_valid,
  output logic [15:0] dmem_rd_data
);
  logic [15:0] mem_r [0:32767];
  logic [3:0] wait_r;
  // ==========
  // Preload: word derived from its address
  initial
  begin
    dmem_rd_valid = 1'b0;
    dmem_rd_data = 16'h5A5A;
    for (int i = 0; i < 32768; i++)
      mem_r[i] = {i[7:0], ~i[7:0]};
  end
  // ==========
  // Read and write
  // Idle data toggles so a late sample never sees the old word
  always @(posedge clk)
  begin
    if (dmem_wr_en)
      mem_r[dmem_addr] <= dmem_wr_data;
    if (!rst_b || !dmem_rd_req || dmem_rd_valid)
    begin
      wait_r <= 4'h0;
      dmem_rd_valid <= 1'b0;
      dmem_rd_data <= ~dmem_rd_data;
    end
    else if (wait_r == lat)
    begin
      dmem_rd_valid <= 1'b1;
      dmem_rd_data <= mem_r[dmem_addr];
    end
    else
    begin
      wait_r <= wait_r + 4'h1;
      dmem_rd_data <= ~dmem_rd_data;
    end
  end
endmodule

/* test/dlbae_exec_test.sv */
// Self-checking bench for the logic, jump and all-pass execution unit
`timescale 1ns/100ps
module dlbae_exec_test
  import dlbae_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic instr_valid = 1'b0;
  logic [31:0] instr_word = 32'h0;
  logic [9:0] instr_pc = 10'h0;
  logic program_change = 1'b0;
  logic reg_wr_en = 1'b0;
  logic [3:0] reg_wr_idx = 4'h0;
  logic [31:0] reg_wr_data = 32'h0;
  logic [31:0] flags_in = 32'h5A5A_00C3;
  logic [3:0] lat = 4'h0;
  logic instr_ready, exec_done, jump_taken, dmem_rd_req, dmem_rd_valid, dmem_wr_en;
  logic [9:0] jump_target;
  logic [14:0] dmem_addr;
  logic [15:0] dmem_rd_data, dmem_wr_data;
  logic [31:0] short_accumulator, parameter_register, acc_m;
  logic [31:0] regs_m [0:15];
  int n_fail = 0;
  int samples_checked = 0;
  logic rd_seen = 1'b0;

  always #5 clk = ~clk;

  // Catch the read request held while the unit stalls
  always @(negedge clk)
  begin
    if (dmem_rd_req === 1'b1 && instr_ready === 1'b0)
      rd_seen = 1'b1;
  end

  dlbae_exec #(.PC_W(10)) u_dut (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_pc(instr_pc), .instr_ready(instr_ready),
    .exec_done(exec_done), .program_change(program_change), .reg_wr_en(reg_wr_en),
    .reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data), .flags_in(flags_in),
    .jump_taken(jump_taken), .jump_target(jump_target), .dmem_rd_req(dmem_rd_req),
    .dmem_addr(dmem_addr), .dmem_rd_valid(dmem_rd_valid), .dmem_rd_data(dmem_rd_data),
    .dmem_wr_en(dmem_wr_en), .dmem_wr_data(dmem_wr_data),
    .short_accumulator(short_accumulator), .parameter_register(parameter_register));

  dlbae_dmem_model u_mem (.clk(clk), .rst_b(rst_b), .lat(lat), .dmem_rd_req(dmem_rd_req),
    .dmem_addr(dmem_addr), .dmem_wr_en(dmem_wr_en), .dmem_wr_data(dmem_wr_data),
    .dmem_rd_valid(dmem_rd_valid), .dmem_rd_data(dmem_rd_data));

  // ==========
  // Helpers
  function automatic logic [31:0] fw(input logic [7:0] op, input logic [4:0] rx,
    input logic [15:0] lo);
    return {op, 3'h0, rx, lo};
  endfunction

  // Signed fraction product, no saturation
  function automatic logic [31:0] mul(input logic [31:0] a, input logic [31:0] b);
    logic signed [63:0] p;
    p = $signed(a) * $signed(b);
    return p[62:31];
  endfunction

  task automatic end_of_test();
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic set_reg(input logic [3:0] idx, input logic [31:0] val);
    @(negedge clk);
    reg_wr_en = 1'b1;
    reg_wr_idx = idx;
    reg_wr_data = val;
    regs_m[idx] = val;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask

  task automatic run(input logic [31:0] w, input logic [9:0] pc, output int n);
    @(negedge clk);
    instr_valid = 1'b1;
    instr_word = w;
    instr_pc = pc;
    @(negedge clk);
    instr_valid = 1'b0;
    n = 0;
    while (exec_done !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    check(32'(exec_done), 32'h1);
  endtask

  task automatic lc(input logic [31:0] w, input logic [31:0] exp);
    int n;
    run(w, 10'h0, n);
    acc_m = exp;
    check(short_accumulator, exp);
  endtask

  // Same offset everywhere; target stays inside a 1024-word program
  task automatic jc(input logic [7:0] op, input logic [4:0] rx, input logic tk);
    int n;
    run(fw(op, rx, 16'h0223), 10'h010, n);
    check(32'(jump_taken), 32'(tk));
    check(32'(jump_target), 32'h233);
  endtask

  task automatic ap_pair(input logic [31:0] w1, input logic [31:0] w2, input logic [14:0] ta,
    input logic [14:0] ha, input logic [31:0] c1, input logic [31:0] c2);
    logic [31:0] tail;
    int n;
    tail = {u_mem_word(ta), 16'h0};
    rd_seen = 1'b0;
    run(w1, 10'h0, n);
    acc_m = acc_m + mul(tail, c1);
    check(32'(n), 32'(lat) + 32'h2);
    check(32'(rd_seen), 32'h1);
    check(32'(dmem_rd_req), 32'h0);
    check(32'(instr_ready), 32'h1);
    check(32'(dmem_addr), 32'(ta));
    check(short_accumulator, acc_m);
    check(parameter_register, tail);
    run(w2, 10'h0, n);
    check(32'(dmem_wr_en), 32'h1);
    check(32'(dmem_wr_data), 32'(acc_m[31:16]));
    check(32'(dmem_addr), 32'(ha));
    acc_m = mul(acc_m, c2) + tail;
    check(short_accumulator, acc_m);
  endtask

  function automatic logic [15:0] u_mem_word(input logic [14:0] a);
    return {a[7:0], ~a[7:0]};
  endfunction

  // ==========
  // Scenarios
  task automatic t_logic();
    set_reg(4'h1, 32'hF0F0_1234);
    set_reg(4'h2, 32'h0FF0_8421);
    lc(fw(OP_BITWISE_INVERT, 5'h01, 16'h0), ~regs_m[1]);
    lc(fw(OP_BITWISE_INVERT, SEL_FLAGS, 16'h0), ~flags_in);
    lc(fw(OP_REG_OR, 5'h01, 16'h0002), regs_m[1] | regs_m[2]);
    lc(fw(OP_REG_AND, 5'h01, 16'h0002), regs_m[1] & regs_m[2]);
    lc(fw(OP_REG_XOR, SEL_SHORT_ACC, 16'h0001), acc_m ^ regs_m[1]);
    lc(fw(OP_REG_XOR, 5'h02, 16'h0001), regs_m[2] ^ regs_m[1]);
    lc(fw(OP_OR_IMMEDIATE, 5'h02, 16'h8001), regs_m[2] | 32'h0000_8001);
    lc(fw(OP_AND_IMMEDIATE, 5'h01, 16'hFFFF), regs_m[1] & 32'h0000_FFFF);
    lc(fw(OP_XOR_IMMEDIATE, 5'h02, 16'h8421), regs_m[2] ^ 32'h0000_8421);
    // Unknown opcode leaves the accumulator alone
    lc(fw(8'hA1, 5'h01, 16'h0), acc_m);
    program_change = 1'b1;
    @(negedge clk);
    program_change = 1'b0;
    acc_m = 32'h0;
    check(short_accumulator, acc_m);
  endtask

  task automatic t_jump();
    set_reg(4'h3, 32'h0);
    set_reg(4'h4, 32'h8000_0000);
    set_reg(4'h5, 32'h7FFF_FFFF);
    jc(OP_JUMP_IF_NONNEGATIVE, 5'h03, 1'b1);
    jc(OP_JUMP_IF_NONNEGATIVE, 5'h04, 1'b0);
    jc(OP_JUMP_IF_NEGATIVE, 5'h04, 1'b1);
    jc(OP_JUMP_IF_NEGATIVE, 5'h03, 1'b0);
    jc(OP_JUMP_IF_NONZERO, 5'h05, 1'b1);
    jc(OP_JUMP_IF_NONZERO, 5'h03, 1'b0);
    jc(OP_JUMP_IF_ZERO, 5'h03, 1'b1);
    jc(OP_JUMP_IF_ZERO, 5'h05, 1'b0);
    lc(fw(OP_BITWISE_INVERT, 5'h03, 16'h0), 32'hFFFF_FFFF);
    jc(OP_JUMP_IF_SIGN_DIFFERS, 5'h05, 1'b1);
    jc(OP_JUMP_IF_SIGN_DIFFERS, 5'h04, 1'b0);
    jc(OP_JUMP_ALWAYS, 5'h00, 1'b1);
  endtask

  task automatic t_allpass();
    set_reg(4'h6, 32'hE000_0000);
    lc(fw(OP_BITWISE_INVERT, 5'h06, 16'h0), ~regs_m[6]);
    lat = 4'h4;
    ap_pair({OP_ALLPASS_FIXED_FIRST, 8'hCD, 16'h00C8}, {OP_ALLPASS_FIXED_SECOND, 8'h33, 16'h0},
      15'h00C8, 15'h0, 32'hCD00_0000, 32'h3300_0000);
    lat = 4'h0;
    set_reg(4'h7, 32'h2000_0000);
    ap_pair(fw(OP_ALLPASS_REGCOEF_FIRST, 5'h07, 16'h7FFF),
      fw(OP_ALLPASS_REGCOEF_SECOND, 5'h07, 16'h0100), 15'h7FFF, 15'h0100,
      -regs_m[7], regs_m[7]);
    lat = 4'h2;
    set_reg(4'h8, 32'hE000_0000);
    set_reg(4'h9, 32'hFFFF_9234);
    ap_pair(fw(OP_ALLPASS_ALLREG_FIRST, 5'h08, 16'h0009),
      fw(OP_ALLPASS_ALLREG_SECOND, 5'h08, 16'h0009), 15'h1234, 15'h1234,
      -regs_m[8], regs_m[8]);
  endtask

  // ==========
  // Main sequence and watchdog
  initial
  begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    check(short_accumulator, SHORT_ACC_RST);
    check(32'(instr_ready), 32'h1);
    t_logic();
    t_jump();
    t_allpass();
    end_of_test();
  end

  initial
  begin
    #20000;
    n_fail++;
    end_of_test();
  end
endmodule
